// [hdl/adcic_defs.svh]
/*
  Constants for the two-wire converter channel controller: timing counts, address codes,
  command field positions and reset values.
  Assumes inclusion by bare name from the package; the design modules use its macros without including it.
*/
// Summary of operation
// [RULE1] channel command arrives as one eight-bit word per write
// [RULE2] reset selects differential pair, input 0 positive, input 1 negative
// [RULE3] first conversion starts by itself after reset
// [RULE4] master sends only 000, 100 or 101 as leading three bits
// [RULE5] leading 000 or 100: rest ignored, previous selection kept
// [RULE6] leading 101: next five bits become selection for next conversion
// [RULE7] first selection bit: 0 differential, 1 single-ended
// [RULE8] differential: pair 2k/2k+1, polarity 1 makes odd channel positive
// [RULE9] single-ended: channel 2k+polarity positive, common pin negative
// [RULE10] after conversion the device sleeps, ready for a read
// [RULE11] acknowledged read in sleep enters data output state
// [RULE12] data output ends, new conversion on stop or after 24 bits
// [RULE13] master aborts a read with stop during the ninth clock
// [RULE14] slave address from three tri-level straps, 27 codes
// [RULE15] global address 1110111 also selects the device
// [RULE16] without writes conversions reuse last or default selection
// [RULE17] addressed during conversion: device answers with NAK
// [RULE18] master writes a selection only after conversion completes
// [RULE19] write, repeated start, read allowed; next conversion uses new selection
// [RULE20] result: sign, over-range, 16-bit two's complement, six zeros
// [RULE21] stop after acknowledged write starts a new conversion
// [RULE22] read to global address is refused with NAK
// [RULE23] conversion lasts a configurable count of oscillator cycles
`ifndef ADCIC_DEFS_SVH
`define ADCIC_DEFS_SVH

`define ADCIC_CLK_MHZ 40
`define ADCIC_CONV_TIME_US 1000
`define ADCIC_CONV_CYCLES (`ADCIC_CONV_TIME_US * `ADCIC_CLK_MHZ)
`define ADCIC_GLOBAL_ADDR 7'h77
`define ADCIC_EN_PATTERN 3'h5
`define ADCIC_SEL_RESET 5'h00
`define ADCIC_RESULT_BITS 24
`define ADCIC_SEL_SGL_BIT 4
`define ADCIC_SEL_ODD_BIT 3
`define ADCIC_STRAP_LOW 2'h0
`define ADCIC_STRAP_HIGH 2'h1
`define ADCIC_STRAP_FLOAT 2'h2

`endif

// [hdl/adcic_pkg.sv]
/*
  Types for the two-wire converter channel controller.
  Assumes the constants header is on the include path.
*/
package adcic_pkg;
  `include "adcic_defs.svh"

  typedef enum logic [1:0] {
    ADCIC_CONVERT,
    ADCIC_SLEEP,
    ADCIC_OUTPUT
  } adcic_state_t;

  typedef struct packed {
    logic single_ended_select;
    logic odd_polarity;
    logic pair_index_bit2;
    logic pair_index_bit1;
    logic pair_index_bit0;
  } adcic_sel_t;

  typedef struct packed {
    logic [3:0] pos_channel;
    logic [3:0] neg_channel;
    logic neg_is_common;
  } adcic_mux_t;

  typedef struct packed {
    logic sign_flag;
    logic over_range;
    logic [15:0] value;
  } adcic_result_t;
endpackage : adcic_pkg

// [hdl/adcic_strap_addr.sv]
/*
  Tri-level strap to slave address decoder.
  Assumes strap levels are already sensed as low, high or float codes and steady.
*/
`timescale 1ns/100ps
`default_nettype none
module adcic_strap_addr (
  input wire logic [1:0] addr_strap_0,
  input wire logic [1:0] addr_strap_1,
  input wire logic [1:0] addr_strap_2,
  output logic [6:0] slave_addr
);
  import adcic_pkg::*;

  // ---------------------------------------------------------
  // address table
  // ---------------------------------------------------------
  function automatic logic [6:0] strap_lookup(input logic [1:0] s2, input logic [1:0] s1, input logic [1:0] s0);
    logic [5:0] key;
    key = {s2, s1, s0};
    unique case (key)
      6'h00: strap_lookup = 7'h14;
      6'h01: strap_lookup = 7'h16;
      6'h02: strap_lookup = 7'h15;
      6'h04: strap_lookup = 7'h26;
      6'h05: strap_lookup = 7'h34;
      6'h06: strap_lookup = 7'h27;
      6'h08: strap_lookup = 7'h17;
      6'h09: strap_lookup = 7'h25;
      6'h0A: strap_lookup = 7'h24;
      6'h10: strap_lookup = 7'h56;
      6'h11: strap_lookup = 7'h64;
      6'h12: strap_lookup = 7'h57;
      6'h14: strap_lookup = 7'h74;
      6'h15: strap_lookup = 7'h76;
      6'h16: strap_lookup = 7'h75;
      6'h18: strap_lookup = 7'h65;
      6'h19: strap_lookup = 7'h67;
      6'h1A: strap_lookup = 7'h66;
      6'h20: strap_lookup = 7'h35;
      6'h21: strap_lookup = 7'h37;
      6'h22: strap_lookup = 7'h36;
      6'h24: strap_lookup = 7'h47;
      6'h25: strap_lookup = 7'h55;
      6'h26: strap_lookup = 7'h54;
      6'h28: strap_lookup = 7'h44;
      6'h29: strap_lookup = 7'h46;
      6'h2A: strap_lookup = 7'h45;
      // code 3 is not a legal strap level; any strap at 3 gives the all-float address
      default: strap_lookup = 7'h45;
    endcase
  endfunction : strap_lookup

  always_comb begin
    slave_addr = strap_lookup(addr_strap_2, addr_strap_1, addr_strap_0); // [RULE14]
  end
endmodule : adcic_strap_addr
`default_nettype wire

// [hdl/adcic_top.sv]
/*
  Two-wire slave controller for a multi-channel converter: address match, channel
  command capture, conversion/sleep/output sequencing and 24-bit result shifting.
  Assumes scl and sda come from pins (resynchronised here), straps are steady, and the
  analog side presents a result word that is sampled at conversion end.
*/
`timescale 1ns/100ps
`default_nettype none
module adcic_top #(
  parameter int unsigned CONV_CYCLES = `ADCIC_CONV_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_strap_0,
  input wire logic [1:0] addr_strap_1,
  input wire logic [1:0] addr_strap_2,
  input wire adcic_pkg::adcic_result_t conv_result,
  output adcic_pkg::adcic_mux_t mux_select,
  output logic converting,
  output logic conv_start
);
  import adcic_pkg::*;

  // ---------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_ff;
  logic sda_ff;

  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    end
  end

  // a level counts once stages two and three agree; otherwise hold the old value
  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_ff <= sda_sync_ff[2];
      end
    end
  end

  logic scl_d_ff;
  logic sda_d_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_ff && !scl_d_ff;
  assign scl_fall = !scl_ff && scl_d_ff;
  assign start_det = scl_ff && scl_d_ff && sda_d_ff && !sda_ff;
  assign stop_det = scl_ff && scl_d_ff && !sda_d_ff && sda_ff;

  // ---------------------------------------------------------
  // address decode
  // ---------------------------------------------------------
  logic [6:0] slave_addr;
  adcic_strap_addr u_strap (
    .addr_strap_0(addr_strap_0),
    .addr_strap_1(addr_strap_1),
    .addr_strap_2(addr_strap_2),
    .slave_addr(slave_addr)
  );

  // ---------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_WDATA,
    BUS_RDATA,
    BUS_IGNORE
  } adcic_bus_t;

  adcic_bus_t bus_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic ack_drive_ff;
  logic wr_acked_ff;
  logic [4:0] rd_bits_ff;
  logic [23:0] out_ff;
  logic sda_out_ff;
  logic sda_oe_ff;
  adcic_state_t state_ff;
  adcic_sel_t sel_ff;
  adcic_result_t result_ff;
  logic [$clog2(CONV_CYCLES + 1)-1:0] conv_cnt_ff;
  logic conv_go;
  logic master_nak_ff;

  logic ninth;
  logic [7:0] rx_byte;
  logic addr_hit;
  logic global_hit;
  assign ninth = (bit_cnt_ff == 4'h9);
  assign rx_byte = {shift_ff[6:0], sda_ff};
  assign global_hit = (shift_ff[7:1] == `ADCIC_GLOBAL_ADDR); // [RULE15]
  assign addr_hit = (shift_ff[7:1] == slave_addr) || global_hit;

  // bit counter and receive shifter, sampled on scl rising edges
  always_ff @(posedge mclk) begin
    if (reset || start_det || stop_det) begin
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end else if (scl_fall && ninth) begin
      bit_cnt_ff <= 4'h0;
    end else if (scl_fall && bit_cnt_ff == 4'h8) begin
      // the ack slot has a count of its own so no data bit is taken in it
      bit_cnt_ff <= 4'h9;
    end else if (scl_rise && bit_cnt_ff < 4'h8) begin
      shift_ff <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  // transaction phase; ack decided at the falling edge ending bit 8
  always_ff @(posedge mclk) begin
    if (reset || stop_det) begin
      bus_ff <= BUS_IDLE;
      ack_drive_ff <= 1'b0;
      master_nak_ff <= 1'b0;
    end else if (start_det) begin
      bus_ff <= BUS_ADDR;
      ack_drive_ff <= 1'b0;
      master_nak_ff <= 1'b0;
    end else if (scl_fall && bit_cnt_ff == 4'h8 && !ack_drive_ff) begin
      unique case (bus_ff)
        BUS_ADDR: begin
          // busy converter stays silent, and global reads are refused
          if (addr_hit && state_ff != ADCIC_CONVERT && !(global_hit && shift_ff[0])) begin // [RULE17] [RULE22]
            ack_drive_ff <= 1'b1;
          end else begin
            bus_ff <= BUS_IGNORE;
          end
        end
        BUS_WDATA: ack_drive_ff <= 1'b1; // [RULE1]
        default: ack_drive_ff <= 1'b0;
      endcase
    end else if (scl_fall && ninth) begin
      ack_drive_ff <= 1'b0;
      if (bus_ff == BUS_ADDR) begin
        bus_ff <= shift_ff[0] ? BUS_RDATA : BUS_WDATA;
      end else if (bus_ff == BUS_RDATA && (master_nak_ff || rd_bits_ff == 5'(`ADCIC_RESULT_BITS))) begin
        bus_ff <= BUS_IGNORE;
      end else if (bus_ff == BUS_WDATA) begin
        bus_ff <= BUS_IGNORE;
      end
    end else if (scl_rise && ninth && bus_ff == BUS_RDATA) begin
      master_nak_ff <= sda_ff;
    end
  end

  // receiving bits 0..7 means shift_ff holds the whole byte once bit_cnt reaches 8
  // note: address byte r/w sits in shift_ff[0] at that point, address in [7:1]

  // ---------------------------------------------------------
  // write capture and channel selection
  // ---------------------------------------------------------
  logic wr_byte_done;
  assign wr_byte_done = scl_fall && ninth && bus_ff == BUS_WDATA;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_ff <= `ADCIC_SEL_RESET; // [RULE2]
    end else if (wr_byte_done && shift_ff[7:5] == `ADCIC_EN_PATTERN) begin
      sel_ff <= shift_ff[4:0]; // [RULE6]
    end
    // other leading patterns leave the selection untouched [RULE5] [RULE16]
  end

  // an acknowledged address write arms the stop that restarts conversion
  always_ff @(posedge mclk) begin
    if (reset || start_det && bus_ff == BUS_IDLE || conv_go) begin
      wr_acked_ff <= 1'b0;
    end else if (scl_fall && ninth && bus_ff == BUS_ADDR && ack_drive_ff && !shift_ff[0]) begin
      wr_acked_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------
  logic rd_acked;
  logic rd_done;
  assign rd_acked = scl_fall && ninth && bus_ff == BUS_ADDR && ack_drive_ff && shift_ff[0];
  assign rd_done = (rd_bits_ff == 5'(`ADCIC_RESULT_BITS)) && scl_fall && ninth;
  assign conv_go = (state_ff == ADCIC_OUTPUT && (stop_det || rd_done)) // [RULE12] [RULE13]
                || (state_ff == ADCIC_SLEEP && stop_det && wr_acked_ff); // [RULE21] [RULE19]

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= ADCIC_CONVERT; // [RULE3]
      conv_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        ADCIC_CONVERT: begin
          if (conv_cnt_ff == ($bits(conv_cnt_ff))'(CONV_CYCLES - 1)) begin
            state_ff <= ADCIC_SLEEP; // [RULE23] [RULE10]
            conv_cnt_ff <= '0;
          end else begin
            conv_cnt_ff <= conv_cnt_ff + 1'b1;
          end
        end
        ADCIC_SLEEP: begin
          if (conv_go) begin
            state_ff <= ADCIC_CONVERT;
          end else if (rd_acked) begin
            state_ff <= ADCIC_OUTPUT; // [RULE11]
          end
        end
        ADCIC_OUTPUT: begin
          if (conv_go) begin
            state_ff <= ADCIC_CONVERT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      result_ff <= '0;
    end else if (state_ff == ADCIC_CONVERT && conv_cnt_ff == ($bits(conv_cnt_ff))'(CONV_CYCLES - 1)) begin
      result_ff <= conv_result;
    end
  end

  // ---------------------------------------------------------
  // data output shifter
  // ---------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      out_ff <= 24'h000000;
      rd_bits_ff <= 5'h00;
    end else if (rd_acked) begin
      out_ff <= {result_ff, 6'h00}; // [RULE20]
      rd_bits_ff <= 5'h00;
    end else if (scl_fall && bus_ff == BUS_RDATA && bit_cnt_ff < 4'h8 && bit_cnt_ff != 4'h0) begin
      out_ff <= {out_ff[22:0], 1'b0};
      rd_bits_ff <= rd_bits_ff + 5'h01;
    end else if (scl_fall && bus_ff == BUS_RDATA && bit_cnt_ff == 4'h8) begin
      out_ff <= {out_ff[22:0], 1'b0};
      rd_bits_ff <= rd_bits_ff + 5'h01;
    end
  end

  // ---------------------------------------------------------
  // sda drive and outputs
  // ---------------------------------------------------------
  logic nxt_sda_oe;
  always_comb begin
    nxt_sda_oe = 1'b0;
    if (ack_drive_ff) begin
      nxt_sda_oe = 1'b1;
    end else if (bus_ff == BUS_RDATA && !ninth && !out_ff[23]) begin
      nxt_sda_oe = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end else begin
      sda_oe_ff <= nxt_sda_oe;
      sda_out_ff <= 1'b0;
    end
  end

  function automatic adcic_mux_t sel_decode(input adcic_sel_t s);
    adcic_mux_t m;
    logic [2:0] k;
    k = {s.pair_index_bit2, s.pair_index_bit1, s.pair_index_bit0};
    m.pos_channel = {k, s.odd_polarity};
    m.neg_channel = {k, !s.odd_polarity};
    m.neg_is_common = s.single_ended_select; // [RULE7] [RULE9]
    if (s.single_ended_select) begin
      m.neg_channel = 4'h0;
    end
    return m; // [RULE8]
  endfunction : sel_decode

  adcic_mux_t mux_ff;
  logic conv_ff;
  logic start_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      mux_ff <= sel_decode(`ADCIC_SEL_RESET);
      conv_ff <= 1'b1;
      start_ff <= 1'b1;
    end else begin
      // selection is frozen while converting so a stray write cannot disturb it [RULE18]
      if (state_ff != ADCIC_CONVERT || conv_go) begin
        mux_ff <= sel_decode(sel_ff);
      end
      conv_ff <= (state_ff == ADCIC_CONVERT);
      start_ff <= conv_go;
    end
  end

  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;
  assign mux_select = mux_ff;
  assign converting = conv_ff;
  assign conv_start = start_ff;
endmodule : adcic_top
`default_nettype wire

// [tb/adcic_assertions.sv]
/*
  Checker for the converter channel controller, bound to adcic_top.
  Assumes a single mclk domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module adcic_chk #(
  parameter int unsigned CONV_CYCLES = 40000
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] addr_strap_0,
  input wire logic [1:0] addr_strap_1,
  input wire logic [1:0] addr_strap_2,
  input wire adcic_pkg::adcic_result_t conv_result,
  input wire adcic_pkg::adcic_mux_t mux_select,
  input wire logic converting,
  input wire logic conv_start
);
  import adcic_pkg::*;
  logic [31:0] cnt_ff;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // a long count is watched through a counter, not a repetition
  always_ff @(posedge mclk) begin
    if (reset || conv_start) cnt_ff <= 32'h0;
    else if (converting) cnt_ff <= cnt_ff + 32'h1;
    else cnt_ff <= 32'h0;
  end
  launch_busy_a: assert property (conv_start |-> ##[0:2] converting)
    else $error("launch without conversion");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("launch pulse too long");
  conv_max_a: assert property (cnt_ff <= CONV_CYCLES + 4)
    else $error("conversion too long");
  conv_min_a: assert property ($fell(converting) |-> cnt_ff + 4 >= CONV_CYCLES)
    else $error("conversion too short");
  busy_nak_a: assert property (converting && $past(converting) |-> !sda_oe)
    else $error("data line driven while converting");
  bit_stand_a: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*4])
    else $error("data line drive too short");
  mux_hold_a: assert property (converting && $past(converting, 2) |-> $stable(mux_select))
    else $error("selection moved in conversion");
  pair_form_a: assert property (!mux_select.neg_is_common |->
    mux_select.pos_channel[3:1] == mux_select.neg_channel[3:1] && mux_select.pos_channel[0] != mux_select.neg_channel[0])
    else $error("differential pair not adjacent");
  reset_default_a: assert property ($fell(reset) |-> (mux_select == 9'h002 && converting) ##[0:1] conv_start)
    else $error("wrong state after reset");
  sleep_hold_a: assert property (!converting && !conv_start ##1 !conv_start |-> !converting)
    else $error("left sleep without launch");
  rose_launch_a: assert property ($rose(converting) |-> conv_start || $past(conv_start))
    else $error("conversion began unlaunched");
endmodule : adcic_chk
bind adcic_top adcic_chk #(.CONV_CYCLES(CONV_CYCLES)) i_adcic_chk (.mclk(mclk), .reset(reset), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(addr_strap_0), .addr_strap_1(addr_strap_1),
  .addr_strap_2(addr_strap_2), .conv_result(conv_result), .mux_select(mux_select), .converting(converting),
  .conv_start(conv_start));
`default_nettype wire

// [tb/adcic_master.sv]
/*
  Behavioural two-wire bus master, 200 ns bus clock period.
  Assumes the bench resolves the pulled-up data wire and feeds it back.
*/
`timescale 1ns/100ps
`default_nettype none
module adcic_master (
  input wire logic mclk,
  input wire logic sda_line,
  output var logic scl,
  output var logic m_oe
);
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
  endtask : gap
  // data moves only while scl is low; long low phase covers the slave's synchroniser lag
  task automatic bit_io(input logic b, output logic r);
    gap(2);
    m_oe <= !b;
    gap(4);
    scl <= 1'b1;
    gap(1);
    #1 r = sda_line;
    gap(1);
    scl <= 1'b0;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
  endtask : byte_io
  // also a repeated start: sda released while scl low first
  task automatic start_c;
    gap(2);
    m_oe <= 1'b0;
    gap(4);
    scl <= 1'b1;
    gap(4);
    m_oe <= 1'b1;
    gap(4);
    scl <= 1'b0;
  endtask : start_c
  // scl then stands still high until the next frame
  task automatic stop_c;
    gap(2);
    m_oe <= 1'b1;
    gap(4);
    scl <= 1'b1;
    gap(4);
    m_oe <= 1'b0;
    gap(4);
  endtask : stop_c
endmodule : adcic_master
`default_nettype wire

// [tb/tb_top.sv]
/*
  Self-checking bench for adcic_top driven through the two-wire master model.
  Assumes a short conversion count and an all-low strap address at start.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adcic_pkg::*;
  localparam int unsigned CONV = 400;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] s0 = 2'h0, s1 = 2'h0, s2 = 2'h0;
  adcic_result_t res = 18'h2A5C3;
  adcic_mux_t mux_select;
  logic scl, m_oe, sda_out, sda_oe, converting, conv_start, sda, ack;
  logic [7:0] q, b0, b1, b2;
  logic [4:0] cur = 5'h00;
  logic [7:0] words [6] = '{8'hB9, 8'h1F, 8'hAF, 8'h9F, 8'hB6, 8'hA0};
  int n_fail = 0;
  int comparisons = 0;
  assign sda = !((sda_oe & !sda_out) | m_oe);
  always #12.5 mclk = !mclk;
  adcic_top #(.CONV_CYCLES(CONV)) i_adcic_top (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(s0), .addr_strap_1(s1), .addr_strap_2(s2),
    .conv_result(res), .mux_select(mux_select), .converting(converting), .conv_start(conv_start));
  adcic_master i_adcic_master (.mclk(mclk), .sda_line(sda), .scl(scl), .m_oe(m_oe));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic wait_conv;
    for (int i = 0; i < CONV + 200; i++) begin
      @(posedge mclk);
      #1;
      if (converting === 1'b0) break;
    end
    chk(24'(converting), 24'h0);
  endtask : wait_conv
  // nak is the expected line level in the ack clock
  task automatic addr(input logic [6:0] a, input logic rd, input logic nak);
    i_adcic_master.start_c();
    i_adcic_master.byte_io({a, rd}, q);
    i_adcic_master.bit_io(1'b1, ack);
    chk(24'(ack), 24'(nak));
  endtask : addr
  task automatic wr(input logic [7:0] w);
    i_adcic_master.byte_io(w, q);
    i_adcic_master.bit_io(1'b1, ack);
    chk(24'(ack), 24'h0);
  endtask : wr
  task automatic rd(input logic mnak, output logic [7:0] d);
    i_adcic_master.byte_io(8'hFF, d);
    i_adcic_master.bit_io(mnak, ack);
  endtask : rd
  task automatic rd3;
    rd(1'b0, b0);
    rd(1'b0, b1);
    rd(1'b1, b2);
    chk({b0, b1, b2}, {res, 6'h00});
  endtask : rd3
  task automatic stop_chk(input logic busy);
    i_adcic_master.stop_c();
    repeat (8) @(posedge mclk);
    #1 chk(24'(converting), 24'(busy));
  endtask : stop_chk
  function automatic logic [8:0] mux_exp(input logic [4:0] s);
    return {s[2:0], s[3], s[2:0], !s[3], s[4]};
  endfunction : mux_exp
  // single-ended drives the negative channel code to 0, not the pair partner mux_exp gives, so it is masked
  task automatic chk_mux;
    logic [8:0] m;
    m = cur[4] ? 9'h1E1 : 9'h1FF;
    chk(24'(mux_select & m), 24'(mux_exp(cur) & m));
  endtask : chk_mux
  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1 chk(24'(converting), 24'h1);
    chk_mux();
    addr(7'h14, 1'b1, 1'b1);
    i_adcic_master.stop_c();
    wait_conv();
    addr(7'h15, 1'b0, 1'b1);
    i_adcic_master.stop_c();
    addr(7'h14, 1'b1, 1'b0);
    rd3();
    repeat (8) @(posedge mclk);
    #1 chk(24'(converting), 24'h1);
    i_adcic_master.stop_c();
    foreach (words[k]) begin
      wait_conv();
      addr(7'h14, 1'b0, 1'b0);
      wr(words[k]);
      if (words[k][7:5] == 3'h5) cur = words[k][4:0];
      stop_chk(1'b1);
      wait_conv();
      chk_mux();
    end
    addr(7'h14, 1'b1, 1'b0);
    rd3();
    stop_chk(1'b1);
    wait_conv();
    chk_mux();
    addr(7'h77, 1'b1, 1'b1);
    stop_chk(1'b0);
    addr(7'h77, 1'b0, 1'b0);
    stop_chk(1'b1);
    wait_conv();
    addr(7'h14, 1'b0, 1'b0);
    wr(8'hB5);
    cur = 5'h15;
    addr(7'h14, 1'b1, 1'b0);
    rd3();
    stop_chk(1'b1);
    @(posedge mclk) res <= 18'h13C0F;
    wait_conv();
    chk_mux();
    addr(7'h14, 1'b1, 1'b0);
    rd(1'b1, b0);
    chk(24'(b0), 24'(res[17:10]));
    stop_chk(1'b1);
    wait_conv();
    @(posedge mclk) {s2, s1, s0} <= 6'h2A;
    addr(7'h45, 1'b0, 1'b0);
    stop_chk(1'b1);
    wait_conv();
    @(posedge mclk) {s2, s1, s0} <= 6'h15;
    addr(7'h76, 1'b0, 1'b0);
    stop_chk(1'b1);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
